// *** logic/radio_cfg_defs.vh ***
// Offsets, field positions, reset values and timing counts of the radio configuration bank.
`ifndef RADIO_CFG_DEFS_VH
`define RADIO_CFG_DEFS_VH
`define OFS_STATE_CFG          8'h17
`define OFS_COMP_CFG           8'h18
`define OFS_STATUS             8'h20
`define OFS_COMMAND            8'h24
`define IDX_STATE_CFG          6'h17
`define IDX_COMP_CFG           6'h18
`define IDX_STATUS             6'h20
`define IDX_COMMAND            6'h24
`define STATE_CFG_RESET        8'h04
`define COMP_CFG_RESET         8'h36
`define STATE_CFG_MASK         8'h3f
`define COMP_CFG_MASK          8'h3f
`define AUTOCAL_HI             5
`define AUTOCAL_LO             4
`define POWER_ON_TIMEOUT_SELECT_HI          3
`define POWER_ON_TIMEOUT_SELECT_LO          2
`define PIN_CTRL_BIT           1
`define OSC_KEEP_ON_BIT        0
`define FREEZE_BIT             5
`define PRE_GAIN_HI            4
`define PRE_GAIN_LO            3
`define POST_GAIN_BIT          2
`define LIMIT_HI               1
`define LIMIT_LO               0
`define AUTOCAL_NEVER          2'h0
`define AUTOCAL_FROM_IDLE      2'h1
`define AUTOCAL_TO_IDLE        2'h2
`define AUTOCAL_FOURTH         2'h3
`define RIPPLE_BITS            6
`define RADIO_IDLE             2'h0
`define RADIO_RX               2'h1
`define RADIO_TX               2'h2
`define RADIO_FSTX_READY       2'h3
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`endif

// *** logic/radio_state_and_freq_comp_config.v ***
// Register bank for radio state machine control and frequency offset compensation settings.
// Functional notes
// - With autocal code 00 the synthesizer is calibrated only by the manual calibrate strobe.
// - With code 01 a calibration is made on each move from idle into receive, transmit or tx-ready.
// - With code 10 a calibration is made on each move from receive or transmit back to idle.
// - With code 11 only every fourth receive/transmit-to-idle move calibrates; field is bits 5:4, reset 00.
// - Chip-ready goes low only after the six-bit ripple counter expired the set number of times.
// - The power-on timeout codes 00..11 select 1, 16, 64 or 256 expirations.
// - Bit 1 of the first register, reset 0, enables pin control of the radio states.
// - Bit 0 of the first register, reset 0, keeps the oscillator on in sleep.
// - Bit 5 of the second register, reset 1, freezes both loops until carrier sense rises.
// - Bits 4:3, reset 10, select pre-sync gain K, 2K, 3K or 4K.
// - After sync the gain is the pre-sync gain if bit 2 is 0, else K/2; bit 2 resets to 1.
// - Bits 1:0, reset 10, clamp the offset to 0, BW/8, BW/4 or BW/2.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_defs.vh"

module radio_state_and_freq_comp_config
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  radio_state,
  input  wire        osc_stable,
  input  wire        carrier_sense,
  input  wire        sync_detected,
  output reg         calibrate_pulse,
  output reg         chip_ready_n,
  output reg         pin_ctrl_enable,
  output reg         osc_keep_on_in_sleep,
  output reg         loop_freeze,
  output reg  [3:0]  comp_gain_x2,
  output reg  [1:0]  comp_offset_limit
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  // Registers sit one per aligned word, so only address bits 7:2 count;
  // the two low bits are ignored rather than refused.
  function [5:0] word_index;
    input [7:0] byte_addr;
    begin
      word_index = byte_addr[7:2];
    end
  endfunction

  function known_index;
    input [5:0] index;
    begin
      known_index = (index == `IDX_STATE_CFG) || (index == `IDX_COMP_CFG)
                    || (index == `IDX_STATUS) || (index == `IDX_COMMAND);
    end
  endfunction

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  reg  [7:0]  state_cfg_reg;
  reg  [7:0]  comp_cfg_reg;
  reg  [7:0]  aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;
  reg         cal_cmd_reg;
  reg  [1:0]  prev_state_reg;
  reg  [1:0]  to_idle_cnt_reg;
  wire        do_write;

  // Address and data beats are taken in either order, each with a one-cycle
  // ready pulse, and held until both are present. The commit waits while an
  // earlier response is still pending, so a second write can never
  // overwrite the first before the master has seen its answer.
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      state_cfg_reg <= `STATE_CFG_RESET;
      comp_cfg_reg  <= `COMP_CFG_RESET;
      cal_cmd_reg   <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
      cal_cmd_reg   <= 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // A write to the read-only status word is answered OKAY and dropped;
        // only words outside the map get an error response.
        if (known_index(word_index(aw_addr_reg)))
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
        // A cleared low byte strobe leaves every register untouched.
        if (w_strb_reg[0])
        begin
          case (word_index(aw_addr_reg))
            `IDX_STATE_CFG:
            begin
              state_cfg_reg <= w_data_reg[7:0] & `STATE_CFG_MASK;
            end
            `IDX_COMP_CFG:
            begin
              comp_cfg_reg <= w_data_reg[7:0] & `COMP_CFG_MASK;
            end
            `IDX_COMMAND:
            begin
              cal_cmd_reg <= w_data_reg[0];
            end
            default:
            begin
              cal_cmd_reg <= 1'b0;
            end
          endcase
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // The answer is built from the address at the handshake edge, so read data
  // stands one cycle after the address is taken and stays until rready; only
  // one read is in flight because arready is held off while rvalid is up.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (word_index(s_axi_araddr))
          `IDX_STATE_CFG:
          begin
            s_axi_rdata <= {24'h000000, state_cfg_reg};
          end
          `IDX_COMP_CFG:
          begin
            s_axi_rdata <= {24'h000000, comp_cfg_reg};
          end
          `IDX_STATUS:
          begin
            // Bit 4 freeze, bit 3 ready, bits 2:1 the to-idle count; the
            // count lets software see where the fourth-move cycle stands.
            s_axi_rdata <= {27'h0000000, loop_freeze, !chip_ready_n, to_idle_cnt_reg, 1'b0};
          end
          `IDX_COMMAND:
          begin
            s_axi_rdata <= 32'h00000000;
          end
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Calibration triggering
  // ----------------------------------------------------------------
  // Transitions are found by comparing the state with its value one cycle
  // earlier, so a pulse comes one cycle after the change is seen. The
  // to-idle count runs in every mode; switching into the fourth-move mode
  // therefore continues from wherever the count stands rather than from
  // zero.
  wire [1:0] autocal;
  wire       from_idle;
  wire       to_idle;

  assign autocal   = state_cfg_reg[`AUTOCAL_HI:`AUTOCAL_LO];
  assign from_idle = (prev_state_reg == `RADIO_IDLE) && (radio_state != `RADIO_IDLE);
  assign to_idle   = ((prev_state_reg == `RADIO_RX) || (prev_state_reg == `RADIO_TX))
                     && (radio_state == `RADIO_IDLE);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_state_reg  <= `RADIO_IDLE;
      to_idle_cnt_reg <= 2'h0;
      calibrate_pulse <= 1'b0;
    end
    else
    begin
      prev_state_reg <= radio_state;
      if (to_idle)
        to_idle_cnt_reg <= to_idle_cnt_reg + 2'h1;
      case (autocal)
        `AUTOCAL_FROM_IDLE: calibrate_pulse <= cal_cmd_reg | from_idle;
        `AUTOCAL_TO_IDLE:   calibrate_pulse <= cal_cmd_reg | to_idle;
        `AUTOCAL_FOURTH:    calibrate_pulse <= cal_cmd_reg | (to_idle && to_idle_cnt_reg == 2'h3);
        default:            calibrate_pulse <= cal_cmd_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Power-on timeout
  // ----------------------------------------------------------------
  // The ripple counter only runs once the oscillator is stable, so a
  // dropout of osc_stable restarts the whole wait.
  // The expiry count saturates at its goal, and ready is never withdrawn
  // while the oscillator stays stable, so a larger timeout code takes effect
  // only after the next dropout; software should change it only while the oscillator is off.
  reg  [`RIPPLE_BITS-1:0] ripple_reg;
  reg  [8:0]              expire_cnt_reg;
  reg  [8:0]              expire_goal;

  always @*
  begin
    case (state_cfg_reg[`POWER_ON_TIMEOUT_SELECT_HI:`POWER_ON_TIMEOUT_SELECT_LO])
      2'h0:    expire_goal = 9'h001;
      2'h1:    expire_goal = 9'h010;
      2'h2:    expire_goal = 9'h040;
      default: expire_goal = 9'h100;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ripple_reg     <= {`RIPPLE_BITS{1'b0}};
      expire_cnt_reg <= 9'h000;
      chip_ready_n   <= 1'b1;
    end
    else if (!osc_stable)
    begin
      ripple_reg     <= {`RIPPLE_BITS{1'b0}};
      expire_cnt_reg <= 9'h000;
      chip_ready_n   <= 1'b1;
    end
    else
    begin
      ripple_reg <= ripple_reg + {{(`RIPPLE_BITS-1){1'b0}}, 1'b1};
      if (&ripple_reg && expire_cnt_reg < expire_goal)
        expire_cnt_reg <= expire_cnt_reg + 9'h001;
      if (expire_cnt_reg >= expire_goal)
        chip_ready_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  // Gain is given in units of K/2 so that the post-sync K/2 is exact.
  // Four bits are needed because the largest pre-sync gain, 4K, is eight
  // of these units.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_ctrl_enable      <= 1'b0;
      osc_keep_on_in_sleep <= 1'b0;
      loop_freeze          <= 1'b1;
      comp_gain_x2         <= 4'h6;
      comp_offset_limit    <= 2'h2;
    end
    else
    begin
      pin_ctrl_enable      <= state_cfg_reg[`PIN_CTRL_BIT];
      osc_keep_on_in_sleep <= state_cfg_reg[`OSC_KEEP_ON_BIT];
      loop_freeze          <= comp_cfg_reg[`FREEZE_BIT] && !carrier_sense;
      if (sync_detected && comp_cfg_reg[`POST_GAIN_BIT])
        comp_gain_x2 <= 4'h1;
      else
        comp_gain_x2 <= {1'b0, comp_cfg_reg[`PRE_GAIN_HI:`PRE_GAIN_LO], 1'b0} + 4'h2;
      comp_offset_limit <= comp_cfg_reg[`LIMIT_HI:`LIMIT_LO];
    end
  end

endmodule // radio_state_and_freq_comp_config
`default_nettype wire

// *** tb/radio_cfg_assertions.sv ***
// Port-level assertions for the radio configuration bank.
`timescale 1ns/1ps
`default_nettype none
module radio_cfg_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        osc_stable,
  input wire logic        carrier_sense,
  input wire logic        sync_detected,
  input wire logic        calibrate_pulse,
  input wire logic        chip_ready_n,
  input wire logic        loop_freeze,
  input wire logic [3:0]  comp_gain_x2
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_freeze_release: assert property (carrier_sense |=> !loop_freeze)
    else $error("loop freeze held under carrier");
  a_pre_gain: assert property (!sync_detected |=> !comp_gain_x2[0] && |comp_gain_x2)
    else $error("gain not a whole multiple before sync");
  a_cal_single: assert property (calibrate_pulse |=> !calibrate_pulse)
    else $error("calibrate pulse too long");
  // The full count is 64 or more stable cycles, so 60 back must already be stable.
  a_ready_wait: assert property ($fell(chip_ready_n) |-> $past(osc_stable, 60))
    else $error("chip ready too early");
  a_ready_drop: assert property (!osc_stable [*2] |=> chip_ready_n)
    else $error("chip ready without oscillator");
  a_ready_hold: assert property (!chip_ready_n && osc_stable |=> !chip_ready_n)
    else $error("chip ready lost");
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // radio_cfg_checker
bind radio_state_and_freq_comp_config radio_cfg_checker chk_i (.*);
`default_nettype wire

// *** tb/radio_state_and_freq_comp_config_bench.sv ***
// Directed register and control checks for the radio configuration bank.
`timescale 1ns/1ps
`default_nettype none
module radio_state_and_freq_comp_config_bench;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, osc_stable, carrier_sense, sync_detected, calibrate_pulse;
  logic        chip_ready_n, pin_ctrl_enable, osc_keep_on_in_sleep, loop_freeze;
  logic [1:0]  s_axi_bresp, s_axi_rresp, radio_state, comp_offset_limit, rresp_v;
  logic [3:0]  comp_gain_x2;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  int          n_fail, comparisons, ncal, base, k;
  int          cal_exp [4] = '{0, 4, 3, 1};
  int          po_n [4] = '{1, 16, 64, 256};
  logic [1:0]  walk [8] = '{1, 0, 2, 0, 3, 0, 1, 0};
  wire logic [31:0] comp_outs = {25'h0, loop_freeze, comp_gain_x2, comp_offset_limit};
  radio_state_and_freq_comp_config DUT (.*);
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) ncal <= ncal + int'(calibrate_pulse === 1'b1);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Response ready stands from the start, so the answer is taken at the edge it is seen;
  // one idle edge closes each call so the next one never re-drives a signal in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (t = 0; t < 50; t++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk("write_wait", 32'h0, 32'(t / 50));
    if (t == 50) end_sim;
  endtask
  task automatic rd(input logic [7:0] a);
    int t;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (t = 0; t < 50; t++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    {rdat, rresp_v} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk("read_wait", 32'h0, 32'(t / 50));
    if (t == 50) end_sim;
  endtask
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, aresetn} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, radio_state, osc_stable} = '0;
    {carrier_sense, sync_detected, s_axi_wstrb} = {2'b00, 4'hf};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h5c);
    chk("cfg_a_reset", 32'h04, rdat);
    rd(8'h60);
    chk("cfg_b_reset", 32'h36, rdat);
    chk("comp_reset", 32'h5a, comp_outs);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h60, 32'((k << 3) | k));
      chk("comp_pre", 32'(((k + 1) << 3) | k), comp_outs);
    end
    wr(8'h60, 32'hff);
    rd(8'h60);
    chk("cfg_b_rsvd", 32'h3f, rdat);
    {sync_detected, carrier_sense} <= 2'b11;
    repeat (2) @(posedge aclk);
    chk("comp_post", 32'h07, comp_outs);
    rd(8'h04);
    chk("unmapped", 32'h2, {rdat[29:0], rresp_v});
    for (k = 0; k < 4; k++)
    begin
      wr(8'h5c, 32'((k << 4) | 3));
      base = ncal;
      foreach (walk[i])
      begin
        radio_state <= walk[i];
        repeat (4) @(posedge aclk);
      end
      chk("autocal", cal_exp[k], 32'(ncal - base));
    end
    chk("pin_keep", 32'h3, {30'h0, pin_ctrl_enable, osc_keep_on_in_sleep});
    base = ncal;
    wr(8'h90, 32'h1);
    repeat (4) @(posedge aclk);
    chk("manual_cal", 32'h1, 32'(ncal - base));
    for (k = 0; k < 4; k++)
    begin
      osc_stable <= 1'b0;
      wr(8'h5c, 32'(k << 2));
      osc_stable <= 1'b1;
      repeat (64 * po_n[k] - 4) @(posedge aclk);
      chk("ready_early", 32'h1, {31'h0, chip_ready_n});
      repeat (10) @(posedge aclk);
      chk("ready_late", 32'h0, {31'h0, chip_ready_n});
    end
    end_sim;
  end
endmodule // radio_state_and_freq_comp_config_bench
`default_nettype wire
